/* mdsc_dac_control.sv */
// Operation
// - Shift serial input only while chip select is low; otherwise ignore clock.
// - Select rising ends shifting and executes the held command word if 24 or more bits were shifted.
// - Serial input is sampled on each rising serial clock edge.
// - Words are 24 or 32 bits; both lengths are accepted.
// - Output echoes input after 32 rising edges, on the next falling edge.
// - Serial output floats whenever chip select is high.
// - Load pin falling while deselected copies all input registers to DACs.
// - Load pin falling while selected defers the copy until select rises.
// - Load pin low powers channels up and blocks software power-down.
// - Toggle falling loads from register A, rising loads from register B.
// - Toggle pin affects only channels with their toggle select bit set.
// - Clear low returns all channels to strap-chosen code and span.
// - Clear also zeroes every control register.
// - Overtemperature flag pulls low when hot; released on next select rise.
// - Three span straps pick power-on span and code for all channels.
// - Any channel can go to the monitor output; disabled means floating.
// - Internal reference drives its pin unless disabled, then disconnects.
// - Grounded compensation strap starts with the internal reference off.
// - Word is command, channel address, then 16-bit code, MSB first.
// - Long word is 8 ignored bits then the 24-bit word.
// - Writes reach input registers only; B is used only for toggling.
// - Update copies an input register into the DAC register.
module mdsc_dac_control (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic serialClk,
    input wire logic chipSelectLoadN,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOutOeN,
    input wire logic asyncLoadPinN,
    input wire logic togglePin,
    input wire logic asyncClearPinN,
    input wire logic dieOverTemp,
    output logic overtempFlagPinOut,
    output logic overtempFlagPinOeN,
    input wire logic [2:0] spanStrapPins,
    input wire logic referenceCompGrounded,
    output logic [mdsc_pkg::CHANNELS*mdsc_pkg::CODE_W-1:0] dacCodeFlat,
    output logic [mdsc_pkg::CHANNELS*mdsc_pkg::SPAN_W-1:0] dacSpanFlat,
    output logic [mdsc_pkg::CHANNELS-1:0] channelPowered,
    output logic muxEnable,
    output logic [mdsc_pkg::ADDR_W-1:0] muxSelect,
    output logic refOutEnable
);

    localparam int NCH = mdsc_pkg::CHANNELS;
    localparam int SYNC_W = 9;

    logic [mdsc_pkg::SHIFT_W-1:0] shiftWord;
    logic [mdsc_pkg::COUNT_W-1:0] bitCount;
    logic [SYNC_W-1:0] syncStage1;
    logic [SYNC_W-1:0] syncStage2;
    logic csHigh;
    logic csHighPrev;
    logic loadLevelN;
    logic loadPrevN;
    logic toggleLevel;
    logic togglePrev;
    logic clearActive;
    logic hotLevel;
    logic [2:0] strapLevel;
    logic refGroundLevel;
    logic [2:0] strapSpan;
    logic csRise;
    logic execNow;
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [15:0] data;
    logic loadPending;
    logic toggleFallPending;
    logic toggleRisePending;
    logic loadServe;
    logic toggleAServe;
    logic toggleBServe;
    logic [NCH-1:0] writeMask;
    logic [NCH-1:0] spanMask;
    logic [NCH-1:0] updateMask;
    logic [NCH-1:0] downMask;
    logic [NCH-1:0] globalMask;
    logic chipDown;
    logic [NCH-1:0] toggleSel;
    logic writeToB;
    logic cfgRefOff;
    logic refDown;
    logic [15:0] inputA [NCH];
    logic [15:0] inputB [NCH];
    logic [15:0] dacCode [NCH];
    logic [2:0] spanInput [NCH];
    logic [2:0] spanDac [NCH];
    logic [15:0] resetCode;
    logic [2:0] resetSpan;

    // One channel, or all of them, as a mask.
    function automatic logic [NCH-1:0] chan_mask(input logic [3:0] a,
                                                input logic all);
        chan_mask = all ? {NCH{1'b1}} : ({{(NCH-1){1'b0}}, 1'b1} << a);
    endfunction : chan_mask

    mdsc_serial_link u_link (
        .serialClk(serialClk),
        .chipSelectLoadN(chipSelectLoadN),
        .serialDataIn(serialDataIn),
        .shiftWord(shiftWord),
        .bitCount(bitCount),
        .serialDataOut(serialDataOut),
        .serialDataOutOeN(serialDataOutOeN)
    );

    // Two-stage synchronizers for every pin level entering the core clock.
    always_ff @(posedge core_clk) begin
        syncStage1 <= {chipSelectLoadN, asyncLoadPinN, togglePin,
                       asyncClearPinN, dieOverTemp, spanStrapPins,
                       referenceCompGrounded};
        syncStage2 <= syncStage1;
    end

    assign csHigh = syncStage2[8];
    assign loadLevelN = syncStage2[7];
    assign toggleLevel = syncStage2[6];
    assign clearActive = !syncStage2[5];
    assign hotLevel = syncStage2[4];
    assign strapLevel = syncStage2[3:1];
    assign refGroundLevel = syncStage2[0];

    // Edge history; loaded from the pins during reset so release makes no
    // false edge.
    always_ff @(posedge core_clk) begin
        csHighPrev <= csHigh;
        loadPrevN <= loadLevelN;
        togglePrev <= toggleLevel;
    end

    // Straps are caught while reset is held; pins are static in use.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            strapSpan <= strapLevel;
        end
    end

    // The shift word is stable here: the shifter moves only while the select
    // is low, so a select-qualified read needs no more crossing.
    assign csRise = csHigh && !csHighPrev;
    assign execNow = csRise && (bitCount >= mdsc_pkg::SHORT_WORD_BITS);
    assign cmd = shiftWord[mdsc_pkg::CMD_MSB:mdsc_pkg::CMD_LSB];
    assign addr = shiftWord[mdsc_pkg::ADDR_MSB:mdsc_pkg::ADDR_LSB];
    assign data = shiftWord[mdsc_pkg::DATA_MSB:0];

    // Pin updates wait for a cycle with no command, so both never hit a
    // DAC register together.
    assign loadServe = loadPending && csHigh && !execNow;
    assign toggleAServe = toggleFallPending && !execNow && !loadServe;
    assign toggleBServe = toggleRisePending && !execNow && !loadServe &&
                          !toggleAServe;

    // Pending pin events; a new edge wins over the serve of the old one.
    always_ff @(posedge core_clk) begin
        if (!rstn || clearActive) begin
            loadPending <= 1'b0;
            toggleFallPending <= 1'b0;
            toggleRisePending <= 1'b0;
        end else begin
            if (loadPrevN && !loadLevelN) begin
                loadPending <= 1'b1;
            end else if (loadServe) begin
                loadPending <= 1'b0;
            end
            if (togglePrev && !toggleLevel) begin
                toggleFallPending <= 1'b1;
            end else if (toggleAServe) begin
                toggleFallPending <= 1'b0;
            end
            if (!togglePrev && toggleLevel) begin
                toggleRisePending <= 1'b1;
            end else if (toggleBServe) begin
                toggleRisePending <= 1'b0;
            end
        end
    end

    // Command decode into channel masks.
    always_comb begin
        writeMask = '0;
        spanMask = '0;
        updateMask = '0;
        downMask = '0;
        globalMask = '0;
        chipDown = 1'b0;
        if (execNow) begin
            case (cmd)
                mdsc_pkg::CMD_WRITE_N: writeMask = chan_mask(addr, 1'b0);
                mdsc_pkg::CMD_WRITE_ALL: writeMask = chan_mask(addr, 1'b1);
                mdsc_pkg::CMD_SPAN_N: spanMask = chan_mask(addr, 1'b0);
                mdsc_pkg::CMD_SPAN_ALL: spanMask = chan_mask(addr, 1'b1);
                mdsc_pkg::CMD_UPDATE_N: updateMask = chan_mask(addr, 1'b0);
                mdsc_pkg::CMD_UPDATE_ALL: updateMask = chan_mask(addr, 1'b1);
                mdsc_pkg::CMD_WRITE_N_UPDATE_N: begin
                    writeMask = chan_mask(addr, 1'b0);
                    updateMask = chan_mask(addr, 1'b0);
                end
                mdsc_pkg::CMD_WRITE_N_UPDATE_ALL: begin
                    writeMask = chan_mask(addr, 1'b0);
                    updateMask = chan_mask(addr, 1'b1);
                end
                mdsc_pkg::CMD_WRITE_ALL_UPDATE_ALL: begin
                    writeMask = chan_mask(addr, 1'b1);
                    updateMask = chan_mask(addr, 1'b1);
                end
                mdsc_pkg::CMD_POWER_DOWN_N: downMask = chan_mask(addr, 1'b0);
                mdsc_pkg::CMD_POWER_DOWN_CHIP: begin
                    downMask = chan_mask(addr, 1'b1);
                    chipDown = 1'b1;
                end
                mdsc_pkg::CMD_GLOBAL_TOGGLE: globalMask = toggleSel;
                default: begin
                end
            endcase
        end
    end

    assign resetSpan = rstn ? strapSpan : strapLevel;
    assign resetCode = mdsc_pkg::strap_code(resetSpan);

    // Code and span registers; clear outranks every command and pin event.
    always_ff @(posedge core_clk) begin
        for (int ch = 0; ch < NCH; ch++) begin
            if (!rstn || clearActive) begin
                inputA[ch] <= resetCode;
                inputB[ch] <= resetCode;
                dacCode[ch] <= resetCode;
                spanInput[ch] <= resetSpan;
                spanDac[ch] <= resetSpan;
            end else begin
                if (writeMask[ch]) begin
                    if (toggleSel[ch] && writeToB) begin
                        inputB[ch] <= data;
                    end else begin
                        inputA[ch] <= data;
                    end
                end
                if (spanMask[ch]) begin
                    spanInput[ch] <= data[mdsc_pkg::SPAN_MSB:0];
                end
                if (updateMask[ch]) begin
                    if (writeMask[ch] && !(toggleSel[ch] && writeToB)) begin
                        dacCode[ch] <= data;
                    end else begin
                        dacCode[ch] <= inputA[ch];
                    end
                    spanDac[ch] <= spanInput[ch];
                end
                if (globalMask[ch]) begin
                    dacCode[ch] <= data[mdsc_pkg::GLOBAL_TOGGLE_BIT] ?
                                   inputB[ch] : inputA[ch];
                end
                if (loadServe) begin
                    dacCode[ch] <= inputA[ch];
                    spanDac[ch] <= spanInput[ch];
                end
                if (toggleAServe && toggleSel[ch]) begin
                    dacCode[ch] <= inputA[ch];
                end
                if (toggleBServe && toggleSel[ch]) begin
                    dacCode[ch] <= inputB[ch];
                end
            end
        end
    end

    // Channel power; a low load pin forces power on and vetoes power-down.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            channelPowered <= {NCH{1'b1}};
        end else if (!loadLevelN) begin
            channelPowered <= {NCH{1'b1}};
        end else begin
            channelPowered <= (channelPowered & ~downMask) | updateMask;
        end
    end

    // Control registers, all zeroed by clear.
    always_ff @(posedge core_clk) begin
        if (!rstn || clearActive) begin
            toggleSel <= '0;
            writeToB <= 1'b0;
            muxEnable <= 1'b0;
            muxSelect <= '0;
            cfgRefOff <= 1'b0;
        end else if (execNow) begin
            case (cmd)
                mdsc_pkg::CMD_TOGGLE_SELECT: toggleSel <= data;
                mdsc_pkg::CMD_GLOBAL_TOGGLE: begin
                    writeToB <= data[mdsc_pkg::GLOBAL_TOGGLE_BIT];
                end
                mdsc_pkg::CMD_MONITOR_MUX: begin
                    muxEnable <= data[mdsc_pkg::MUX_ENABLE_BIT];
                    muxSelect <= data[mdsc_pkg::MUX_SEL_MSB:0];
                end
                mdsc_pkg::CMD_POWER_DOWN_CHIP: begin
                    if (loadLevelN) begin
                        muxEnable <= 1'b0;
                    end
                end
                mdsc_pkg::CMD_CONFIG: begin
                    cfgRefOff <= data[mdsc_pkg::CFG_REF_OFF_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Reference power: off from reset when the strap is grounded, off on a
    // chip power-down with the load pin high, back on with any update or a low load pin.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            refDown <= refGroundLevel;
        end else if (chipDown && loadLevelN) begin
            refDown <= 1'b1;
        end else if (updateMask != '0 || !loadLevelN) begin
            refDown <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            refOutEnable <= 1'b0;
        end else begin
            refOutEnable <= !refDown && !cfgRefOff;
        end
    end

    // Open-drain flag; a hot level in the release cycle keeps it set.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            overtempFlagPinOeN <= 1'b1;
            overtempFlagPinOut <= 1'b0;
        end else begin
            overtempFlagPinOut <= 1'b0;
            if (hotLevel) begin
                overtempFlagPinOeN <= 1'b0;
            end else if (csRise) begin
                overtempFlagPinOeN <= 1'b1;
            end
        end
    end

    // Flatten channel registers onto the output buses.
    always_comb begin
        dacCodeFlat = '0;
        dacSpanFlat = '0;
        for (int ch = 0; ch < NCH; ch++) begin
            dacCodeFlat[ch*mdsc_pkg::CODE_W +: mdsc_pkg::CODE_W] = dacCode[ch];
            dacSpanFlat[ch*mdsc_pkg::SPAN_W +: mdsc_pkg::SPAN_W] = spanDac[ch];
        end
    end

endmodule : mdsc_dac_control

/* mdsc_pkg.sv */
package mdsc_pkg;

    // Array shape of the converter core.
    localparam int CHANNELS = 16;
    localparam int CODE_W = 16;
    localparam int SPAN_W = 3;
    localparam int ADDR_W = 4;
    localparam int CMD_W = 4;

    // Serial word geometry; the command word is the last 24 bits shifted.
    localparam int SHIFT_W = 32;
    localparam int COUNT_W = 6;
    localparam logic [5:0] SHORT_WORD_BITS = 6'h18;
    localparam logic [5:0] COUNT_MAX = 6'h3F;
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int ADDR_MSB = 19;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;

    // Command field encodings.
    localparam logic [3:0] CMD_WRITE_N = 4'h0;
    localparam logic [3:0] CMD_WRITE_ALL = 4'h8;
    localparam logic [3:0] CMD_SPAN_N = 4'h6;
    localparam logic [3:0] CMD_SPAN_ALL = 4'hE;
    localparam logic [3:0] CMD_UPDATE_N = 4'h1;
    localparam logic [3:0] CMD_UPDATE_ALL = 4'h9;
    localparam logic [3:0] CMD_WRITE_N_UPDATE_N = 4'h3;
    localparam logic [3:0] CMD_WRITE_N_UPDATE_ALL = 4'h2;
    localparam logic [3:0] CMD_WRITE_ALL_UPDATE_ALL = 4'hA;
    localparam logic [3:0] CMD_POWER_DOWN_N = 4'h4;
    localparam logic [3:0] CMD_POWER_DOWN_CHIP = 4'h5;
    localparam logic [3:0] CMD_MONITOR_MUX = 4'hB;
    localparam logic [3:0] CMD_TOGGLE_SELECT = 4'hC;
    localparam logic [3:0] CMD_GLOBAL_TOGGLE = 4'hD;
    localparam logic [3:0] CMD_CONFIG = 4'h7;
    localparam logic [3:0] CMD_NOP = 4'hF;

    // Data field positions of the control commands, and the mid-scale strap bit.
    localparam int GLOBAL_TOGGLE_BIT = 0;
    localparam int CFG_REF_OFF_BIT = 1;
    localparam int MUX_ENABLE_BIT = 4;
    localparam int MUX_SEL_MSB = 3;
    localparam int SPAN_MSB = 2;
    localparam int STRAP_MID_BIT = 1;

    // Reset codes selected by the span straps.
    localparam logic [15:0] CODE_ZERO_SCALE = 16'h0000;
    localparam logic [15:0] CODE_MID_SCALE = 16'h8000;

    // Die temperature above which the thermal sensor raises its level.
    localparam int OVERTEMP_LIMIT_C = 160;

    // Power-on code chosen by the straps.
    function automatic logic [15:0] strap_code(input logic [2:0] strap);
        strap_code = strap[STRAP_MID_BIT] ? CODE_MID_SCALE : CODE_ZERO_SCALE;
    endfunction : strap_code

endpackage : mdsc_pkg

/* mdsc_serial_link.sv */
// Link-side shifter, clocked only by the host serial clock.
module mdsc_serial_link (
    input wire logic serialClk,
    input wire logic chipSelectLoadN,
    input wire logic serialDataIn,
    output logic [mdsc_pkg::SHIFT_W-1:0] shiftWord,
    output logic [mdsc_pkg::COUNT_W-1:0] bitCount,
    output logic serialDataOut,
    output logic serialDataOutOeN
);

    logic frameStart;

    // Armed while the select is high, so the first edge of a frame restarts
    // the count; the serial clock may be idle between frames.
    always_ff @(posedge serialClk or posedge chipSelectLoadN) begin
        if (chipSelectLoadN) begin
            frameStart <= 1'b1;
        end else begin
            frameStart <= 1'b0;
        end
    end

    // Sample on the rising edge only while selected.
    always_ff @(posedge serialClk) begin
        if (!chipSelectLoadN) begin
            shiftWord <= {shiftWord[mdsc_pkg::SHIFT_W-2:0], serialDataIn};
        end
    end

    // The count saturates and is held after the frame for the core to read.
    always_ff @(posedge serialClk) begin
        if (!chipSelectLoadN) begin
            if (frameStart) begin
                bitCount <= 6'h01;
            end else if (bitCount != mdsc_pkg::COUNT_MAX) begin
                bitCount <= bitCount + 6'h01;
            end
        end
    end

    // Echo the far end of the register on the falling edge.
    always_ff @(negedge serialClk) begin
        serialDataOut <= shiftWord[mdsc_pkg::SHIFT_W-1];
    end

    // Release the pin at once when the select rises.
    always_ff @(negedge serialClk or posedge chipSelectLoadN) begin
        if (chipSelectLoadN) begin
            serialDataOutOeN <= 1'b1;
        end else begin
            serialDataOutOeN <= 1'b0;
        end
    end

endmodule : mdsc_serial_link

/* mdsc_dac_control_props.sv */
module mdsc_dac_control_props (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic serialClk,
    input wire logic chipSelectLoadN,
    input wire logic serialDataIn,
    input wire logic serialDataOut,
    input wire logic serialDataOutOeN,
    input wire logic asyncLoadPinN,
    input wire logic asyncClearPinN,
    input wire logic dieOverTemp,
    input wire logic overtempFlagPinOut,
    input wire logic overtempFlagPinOeN,
    input wire logic [2:0] spanStrapPins,
    input wire logic referenceCompGrounded,
    input wire logic [255:0] dacCodeFlat,
    input wire logic [47:0] dacSpanFlat,
    input wire logic [15:0] channelPowered,
    input wire logic muxEnable,
    input wire logic refOutEnable
);
    // Link side has no reset, so the history fill is counted instead.
    logic [31:0] hist = 32'h0000_0000;
    logic [5:0] fill = 6'h00;
    always_ff @(posedge serialClk) begin
        if (!chipSelectLoadN) begin
            hist <= {hist[30:0], serialDataIn};
            fill <= (fill == 6'h20) ? fill : fill + 6'h01;
        end
    end
    // Core cycles since select last rose; saturates so it never wraps.
    logic csPrev = 1'b1;
    logic [3:0] csAge = 4'hF;
    always_ff @(posedge core_clk) begin
        csPrev <= chipSelectLoadN;
        if (chipSelectLoadN && !csPrev) csAge <= 4'h0;
        else if (csAge != 4'hF) csAge <= csAge + 4'h1;
    end
    sequence clrHeld;
        !asyncClearPinN [*6];
    endsequence
    sequence hotRise;
        $rose(dieOverTemp);
    endsequence
    AST_SDO_FLOAT: assert property (@(posedge core_clk)
        disable iff (!rstn) chipSelectLoadN |-> serialDataOutOeN)
        else $error("echo driven");
    AST_SDO_ECHO: assert property (@(posedge serialClk)
        disable iff (chipSelectLoadN) (fill == 6'h20 && !serialDataOutOeN)
        |-> serialDataOut == hist[31]) else $error("echo bit wrong");
    AST_OVT_OUT: assert property (@(posedge core_clk)
        disable iff (!rstn) !overtempFlagPinOeN |-> !overtempFlagPinOut)
        else $error("flag high");
    AST_OVT_SET: assert property (@(posedge core_clk)
        disable iff (!rstn) hotRise |-> ##[2:5] !overtempFlagPinOeN)
        else $error("flag late");
    AST_OVT_HOLD: assert property (@(posedge core_clk)
        disable iff (!rstn) $rose(overtempFlagPinOeN) |-> csAge <= 4'h6)
        else $error("flag freed");
    AST_CLR_STATE: assert property (@(posedge core_clk)
        disable iff (!rstn) clrHeld |-> dacSpanFlat == {16{spanStrapPins}}
        && !muxEnable && dacCodeFlat == {16{spanStrapPins[1], 15'h0000}})
        else $error("clear incomplete");
    AST_LOAD_PWR: assert property (@(posedge core_clk)
        disable iff (!rstn) !asyncLoadPinN [*6] |-> &channelPowered)
        else $error("not powered");
    // The reference enable follows the strap one edge after release.
    AST_REF_STRAP: assert property (@(posedge core_clk)
        disable iff (!rstn) $rose(rstn) |-> ##1
        refOutEnable == !referenceCompGrounded) else $error("ref strap");
    // The reset check cannot be disabled by the reset it watches.
    AST_RST_VALUES: assert property (@(posedge core_clk)
        !rstn ##1 !rstn |-> &channelPowered && !muxEnable
        && overtempFlagPinOeN) else $error("reset values");
endmodule : mdsc_dac_control_props

bind mdsc_dac_control mdsc_dac_control_props chk_u (.core_clk, .rstn,
    .serialClk, .chipSelectLoadN, .serialDataIn, .serialDataOut,
    .serialDataOutOeN, .asyncLoadPinN, .asyncClearPinN, .dieOverTemp,
    .overtempFlagPinOut, .overtempFlagPinOeN, .spanStrapPins,
    .referenceCompGrounded, .dacCodeFlat, .dacSpanFlat, .channelPowered,
    .muxEnable, .refOutEnable);

/* mdsc_spi_host.sv */
module mdsc_spi_host (
    output logic serialClk,
    output logic chipSelectLoadN,
    output logic serialDataIn,
    input wire logic serialDataOut,
    input wire logic serialDataOutOeN
);
    timeunit 1ns;
    timeprecision 100ps;
    // Pull-up on the echo line: a floating output reads as one.
    wire logic sdoWire = serialDataOutOeN ? 1'b1 : serialDataOut;
    // Clock stands low and select high between frames.
    // The link has no reset: a select rise after time zero arms its frame
    // counter, since a rise at time zero may race the listening process.
    initial begin
        serialClk = 1'b0;
        serialDataIn = 1'b0;
        chipSelectLoadN = 1'b0;
        #1;
        chipSelectLoadN = 1'b1;
    end
    // Data changes mid-low so it is stable around each rising edge.
    task automatic send(input logic [31:0] word, input int nBits,
        output logic [31:0] echo);
        echo = 32'h0000_0000;
        chipSelectLoadN = 1'b0;
        #20;
        for (int i = nBits - 1; i >= 0; i--) begin
            serialDataIn = word[i];
            #31;
            serialClk = 1'b1;
            echo = {echo[30:0], sdoWire};
            #62;
            serialClk = 1'b0;
            #32;
        end
        #20;
        chipSelectLoadN = 1'b1;
        serialDataIn = ~serialDataIn;
        #60;
    endtask : send
endmodule : mdsc_spi_host

/* tb_top.sv */
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR t=%0t got %h want %h", $time, (a), (b)); end end
`define CODE(c) dacCodeFlat[16*(c)+:16]
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, rstn, asyncLoadPinN, togglePin, asyncClearPinN;
    logic dieOverTemp, referenceCompGrounded, serialDataOut;
    logic serialClk, chipSelectLoadN, serialDataIn, serialDataOutOeN;
    logic overtempFlagPinOut, overtempFlagPinOeN, muxEnable, refOutEnable;
    logic [2:0] spanStrapPins;
    logic [3:0] muxSelect;
    logic [255:0] dacCodeFlat;
    logic [47:0] dacSpanFlat;
    logic [15:0] channelPowered;
    logic [31:0] echo;
    int err_count = 0;
    int n_checks = 0;
    mdsc_spi_host host_u (.serialClk, .chipSelectLoadN, .serialDataIn,
        .serialDataOut, .serialDataOutOeN);
    mdsc_dac_control dut_u (.core_clk, .rstn, .serialClk, .chipSelectLoadN,
        .serialDataIn, .serialDataOut, .serialDataOutOeN, .asyncLoadPinN,
        .togglePin, .asyncClearPinN, .dieOverTemp, .overtempFlagPinOut,
        .overtempFlagPinOeN, .spanStrapPins, .referenceCompGrounded,
        .dacCodeFlat, .dacSpanFlat, .channelPowered, .muxEnable, .muxSelect,
        .refOutEnable);
    // Core clock, 5 ns period.
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic wc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wc
    // One frame, then enough core cycles for the command to land.
    task automatic fr(input logic [31:0] w, input int n);
        host_u.send(w, n, echo);
        wc(12);
    endtask : fr
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report
    task automatic t_serial;
        `CHK(`CODE(0), 16'h8000)
        `CHK(dacSpanFlat, {16{3'h2}})
        `CHK(refOutEnable, 1'b0)
        fr(32'h0005_1234, 24);
        fr(32'h0065_0004, 24);
        `CHK(`CODE(5), 16'h8000)
        `CHK(dacSpanFlat[17:15], 3'h2)
        fr(32'h0015_0000, 32);
        `CHK(`CODE(5), 16'h1234)
        `CHK(dacSpanFlat[17:15], 3'h4)
        `CHK(refOutEnable, 1'b1)
        fr(32'h0070_0002, 24);
        `CHK(refOutEnable, 1'b0)
        fr(32'h0000_FFFF, 16);
        `CHK(`CODE(5), 16'h1234)
        fr(32'h0F36_4321, 28);
        `CHK(`CODE(6), 16'h4321)
        fr(32'h5AF0_0000, 32);
        fr(32'h00F0_0000, 32);
        `CHK(echo, 32'hDAF0_0000)
        $display("serial test done");
    endtask : t_serial
    task automatic t_load;
        fr(32'h0002_4444, 24);
        asyncLoadPinN = 1'b0;
        wc(10);
        `CHK(`CODE(2), 16'h4444)
        fr(32'h0043_0000, 24);
        `CHK(channelPowered[3], 1'b1)
        asyncLoadPinN = 1'b1;
        wc(4);
        fork
            host_u.send(32'h0003_7777, 24, echo);
            begin
                #300 asyncLoadPinN = 1'b0;
                #1000 `CHK(`CODE(3), 16'h8000)
            end
        join
        wc(12);
        `CHK(`CODE(3), 16'h7777)
        asyncLoadPinN = 1'b1;
        fr(32'h0043_0000, 24);
        `CHK(channelPowered[3], 1'b0)
        $display("load test done");
    endtask : t_load
    // Channel 4 is not toggle-selected but holds a new code in register A,
    // so a falling toggle that ignored the select would move it.
    task automatic t_toggle;
        fr(32'h00C0_0002, 24);
        fr(32'h0001_1111, 24);
        fr(32'h00D0_0001, 24);
        fr(32'h0001_2222, 24);
        fr(32'h0004_3333, 24);
        togglePin = 1'b1;
        wc(10);
        `CHK(`CODE(1), 16'h2222)
        `CHK(`CODE(4), 16'h8000)
        togglePin = 1'b0;
        wc(10);
        `CHK(`CODE(1), 16'h1111)
        `CHK(`CODE(4), 16'h8000)
        $display("toggle test done");
    endtask : t_toggle
    task automatic t_flags;
        dieOverTemp = 1'b1;
        wc(3);
        dieOverTemp = 1'b0;
        wc(20);
        `CHK(overtempFlagPinOeN, 1'b0)
        fr(32'h00F0_0000, 24);
        `CHK(overtempFlagPinOeN, 1'b1)
        fr(32'h00A0_5555, 24);
        fr(32'h00B0_0013, 24);
        `CHK({muxEnable, muxSelect}, 5'h13)
        asyncClearPinN = 1'b0;
        wc(8);
        asyncClearPinN = 1'b1;
        wc(4);
        `CHK(`CODE(9), 16'h8000)
        `CHK(muxEnable, 1'b0)
        $display("flag and clear test done");
    endtask : t_flags
    // Main sequence; static strap inputs set the power-on state.
    initial begin
        rstn = 1'b0;
        asyncLoadPinN = 1'b1;
        togglePin = 1'b0;
        asyncClearPinN = 1'b1;
        dieOverTemp = 1'b0;
        spanStrapPins = 3'h2;
        referenceCompGrounded = 1'b1;
        wc(5);
        rstn = 1'b1;
        wc(4);
        t_serial();
        t_load();
        t_toggle();
        t_flags();
        final_report();
    end
    // Watchdog: the tests need about a sixth of this span.
    initial begin
        #400000;
        err_count++;
        final_report();
    end
endmodule : tb_top
